/* verilog/ppp_pkg.sv */
package ppp_pkg;
    localparam int CLK_NS = 25;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int MODE_W = 4;
    localparam int CTL_W = 4;
    localparam int CNT_W = 20;
    localparam int MEM_BYTES = 12288;
    localparam logic [ADDR_W-1:0] MEM_LAST = 14'h2fff;
    localparam logic [DATA_W-1:0] ERASED = 8'hff;
    // Mode pins packed as {a, b, c, d}
    localparam logic [MODE_W-1:0] MODE_WRITE = 4'h7;
    localparam logic [MODE_W-1:0] MODE_READ = 4'h3;
    localparam logic [MODE_W-1:0] MODE_ERASE = 4'h8;
    localparam logic [MODE_W-1:0] MODE_LOCK_WR = 4'ha;
    localparam logic [MODE_W-1:0] MODE_LOCK_RD = 4'hc;
    localparam logic [MODE_W-1:0] MODE_ID_RD = 4'h0;
    localparam logic [MODE_W-1:0] MODE_FUSE_WR = 4'h5;
    localparam logic [MODE_W-1:0] MODE_FUSE_RD = 4'hd;
    localparam logic [MODE_W-1:0] MODE_NONE = 4'hf;
    localparam logic [ADDR_W-1:0] ID_ADDR_MFR = 14'h0030;
    localparam logic [ADDR_W-1:0] ID_ADDR_DEV = 14'h0031;
    localparam int LOCK1_WR_BIT = 7;
    localparam int LOCK2_WR_BIT = 6;
    localparam int LOCK3_WR_BIT = 5;
    localparam int LOCK1_RD_BIT = 2;
    localparam int LOCK2_RD_BIT = 1;
    localparam int LOCK3_RD_BIT = 0;
    localparam int FUSE_BIT = 0;
    localparam logic FUSE_RESET = 1'b0;
    // Times in ns, counts in mclk cycles
    localparam int T_PW_MIN_NS = 1000;
    localparam int T_PW_MAX_NS = 110_000;
    localparam int T_PW_NS = 2000;
    localparam int T_ERASE_PW_NS = 10_000_000;
    localparam int T_BUSY_NS = 1000;
    localparam int T_WC_NS = 2_000_000;
    localparam int SETUP_CYC = 48;
    localparam int PW_CYC = (T_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_PW_CYC = (T_ERASE_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_MAX_CYC = T_BUSY_NS / CLK_NS;
    localparam int WC_CYC = T_WC_NS / CLK_NS;
    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_ERASE, OP_LOCK_WR,
        OP_LOCK_RD, OP_ID_RD, OP_FUSE_WR, OP_FUSE_RD
    } ppp_op_t;
    typedef enum logic [1:0] {
        DS_IDLE = 2'h0, DS_BUSY = 2'h1, DS_ERASE = 2'h3
    } ppp_dev_state_t;
    typedef enum logic [2:0] {
        PS_IDLE = 3'h0, PS_SETUP = 3'h1, PS_PULSE = 3'h3,
        PS_HOLD = 3'h2, PS_WAIT_RDY = 3'h6, PS_DONE = 3'h7
    } ppp_prg_state_t;
endpackage : ppp_pkg

/* verilog/ppp_if.sv */
`timescale 1ns/1ps
interface ppp_if;
    logic rst_pin;
    logic code_fetch_strobe_n;
    logic vpp_on;
    logic mode_sel_a;
    logic mode_sel_b;
    logic mode_sel_c;
    logic mode_sel_d;
    logic prog_strobe_n;
    logic [5:0] prog_addr_high;
    logic [7:0] prog_addr_low;
    logic [7:0] prg_data_out;
    logic prg_data_oe;
    logic [7:0] dev_data_out;
    logic dev_data_oe;
    logic [7:0] prog_data_port;
    logic rb_out;
    logic rb_oe;
    logic ready_busy_pin;
    // Pullups when nobody drives
    assign prog_data_port = dev_data_oe ? dev_data_out :
                            (prg_data_oe ? prg_data_out : ppp_pkg::ERASED);
    assign ready_busy_pin = rb_oe ? rb_out : 1'b1;
    modport dev (
        input rst_pin, code_fetch_strobe_n, vpp_on, mode_sel_a, mode_sel_b,
        input mode_sel_c, mode_sel_d, prog_strobe_n, prog_addr_high, prog_addr_low,
        input prog_data_port,
        output dev_data_out, dev_data_oe, rb_out, rb_oe
    );
    modport prg (
        output rst_pin, code_fetch_strobe_n, vpp_on, mode_sel_a, mode_sel_b,
        output mode_sel_c, mode_sel_d, prog_strobe_n, prog_addr_high, prog_addr_low,
        output prg_data_out, prg_data_oe,
        input prog_data_port, ready_busy_pin
    );
endinterface : ppp_if

/* verilog/ppp_device.sv */
`timescale 1ns/1ps
module ppp_device #(
    parameter int WRITE_CYCLES = ppp_pkg::WC_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    ppp_if.dev link,
    output logic [2:0] lock_bits,
    output logic serial_prog_fuse,
    output logic prog_busy
);
    import ppp_pkg::*;

    localparam int IN_W = CTL_W + MODE_W + ADDR_W + DATA_W;
    // Idle pin levels; strobe high so reset gives no false rise
    localparam logic [IN_W-1:0] PIN_IDLE = {4'h5, MODE_NONE, {ADDR_W{1'b0}}, ERASED};

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [IN_W-1:0] pin_meta;
    logic [IN_W-1:0] pin_sync;
    logic rst_s;
    logic code_fetch_strobe_n_n_s;
    logic vpp_s;
    logic strobe_n_s;
    logic [MODE_W-1:0] mode_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= {link.rst_pin, link.code_fetch_strobe_n, link.vpp_on,
                         link.prog_strobe_n, link.mode_sel_a, link.mode_sel_b,
                         link.mode_sel_c, link.mode_sel_d, link.prog_addr_high,
                         link.prog_addr_low, link.prog_data_port};
            pin_sync <= pin_meta;
        end
    end

    assign {rst_s, code_fetch_strobe_n_n_s, vpp_s, strobe_n_s, mode_s, addr_s, data_s} = pin_sync;

    // ------------------------------------------------------------
    // Strobe edge
    // ------------------------------------------------------------
    logic prog_mode;
    logic strobe_d;
    logic strobe_rise;
    logic addr_ok;

    assign prog_mode = rst_s & ~code_fetch_strobe_n_n_s & vpp_s;
    assign addr_ok = (addr_s <= MEM_LAST);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strobe_d <= 1'b1;
        end else begin
            strobe_d <= strobe_n_s;
        end
    end

    assign strobe_rise = prog_mode & strobe_n_s & ~strobe_d;

    // ------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------
    ppp_dev_state_t state;
    logic [CNT_W-1:0] timer;
    logic [ADDR_W-1:0] erase_addr;
    logic start;

    assign start = (state == DS_IDLE) && strobe_rise;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= DS_IDLE;
            timer <= '0;
            erase_addr <= '0;
        end else begin
            case (state)
                DS_IDLE: begin
                    if (start) begin
                        case (mode_s)
                            MODE_WRITE, MODE_LOCK_WR, MODE_FUSE_WR: begin
                                state <= DS_BUSY;
                                timer <= CNT_W'(WRITE_CYCLES - 1);
                            end
                            MODE_ERASE: begin
                                state <= DS_ERASE;
                                erase_addr <= '0;
                            end
                            default: begin
                                state <= DS_IDLE;
                            end
                        endcase
                    end
                end
                DS_BUSY: begin
                    if (timer == '0) begin
                        state <= DS_IDLE;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                DS_ERASE: begin
                    if (erase_addr == MEM_LAST) begin
                        state <= DS_IDLE;
                    end else begin
                        erase_addr <= erase_addr + 1'b1;
                    end
                end
                default: begin
                    state <= DS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flash array
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [MEM_BYTES];
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [DATA_W-1:0] mem_wd;

    always_comb begin
        mem_we = 1'b0;
        mem_wa = addr_s;
        mem_wd = data_s;
        if (state == DS_ERASE) begin
            mem_we = 1'b1;
            mem_wa = erase_addr;
            mem_wd = ERASED;
        end else if (start && mode_s == MODE_WRITE && addr_ok) begin
            mem_we = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ------------------------------------------------------------
    // Lock bits and serial-programming fuse
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lock_bits <= '0;
        end else if (start && mode_s == MODE_ERASE) begin
            lock_bits <= '0;
        end else if (start && mode_s == MODE_LOCK_WR) begin
            lock_bits <= lock_bits | {~data_s[LOCK3_WR_BIT], ~data_s[LOCK2_WR_BIT],
                                      ~data_s[LOCK1_WR_BIT]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            serial_prog_fuse <= FUSE_RESET;
        end else if (start && mode_s == MODE_FUSE_WR) begin
            serial_prog_fuse <= data_s[FUSE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic read_mode;
    logic [DATA_W-1:0] next_rd;

    // Identity bytes, values arbitrary
    localparam logic [DATA_W-1:0] MFR_CODE = 8'h5a;
    localparam logic [DATA_W-1:0] DEV_CODE = 8'ha5;

    assign read_mode = (mode_s == MODE_READ) || (mode_s == MODE_LOCK_RD) ||
                       (mode_s == MODE_ID_RD) || (mode_s == MODE_FUSE_RD);

    always_comb begin
        next_rd = ERASED;
        case (mode_s)
            MODE_READ: begin
                next_rd = addr_ok ? mem[addr_s] : ERASED;
            end
            MODE_LOCK_RD: begin
                next_rd = '0;
                next_rd[LOCK1_RD_BIT] = lock_bits[0];
                next_rd[LOCK2_RD_BIT] = lock_bits[1];
                next_rd[LOCK3_RD_BIT] = lock_bits[2];
            end
            MODE_ID_RD: begin
                if (addr_s == ID_ADDR_MFR) begin
                    next_rd = MFR_CODE;
                end else if (addr_s == ID_ADDR_DEV) begin
                    next_rd = DEV_CODE;
                end
            end
            MODE_FUSE_RD: begin
                next_rd = '0;
                next_rd[FUSE_BIT] = serial_prog_fuse;
            end
            default: begin
                next_rd = ERASED;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link.dev_data_out <= ERASED;
            link.dev_data_oe <= 1'b0;
        end else begin
            link.dev_data_out <= next_rd;
            link.dev_data_oe <= prog_mode && strobe_n_s && read_mode &&
                                (state == DS_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Ready/busy pin
    // ------------------------------------------------------------
    logic op_start;

    // Only listed modifying operations show busy
    assign op_start = start && ((mode_s == MODE_WRITE) || (mode_s == MODE_LOCK_WR) ||
                                (mode_s == MODE_FUSE_WR) || (mode_s == MODE_ERASE));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link.rb_oe <= 1'b0;
        end else begin
            link.rb_oe <= (state != DS_IDLE) || op_start;
        end
    end

    assign link.rb_out = 1'b0;
    assign prog_busy = link.rb_oe;
endmodule : ppp_device

/* verilog/ppp_programmer.sv */
`timescale 1ns/1ps
module ppp_programmer #(
    parameter int ERASE_PULSE_CYCLES = ppp_pkg::ERASE_PW_CYC,
    parameter int READY_TIMEOUT_CYCLES = ppp_pkg::WC_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    ppp_if.prg link,
    input wire logic prog_enable,
    input wire logic op_valid,
    output logic op_ready,
    input wire ppp_pkg::ppp_op_t op_code,
    input wire logic [ppp_pkg::ADDR_W-1:0] op_addr,
    input wire logic [ppp_pkg::DATA_W-1:0] op_wdata,
    output logic rsp_valid,
    output logic [ppp_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_error
);
    import ppp_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [DATA_W:0] in_meta;
    logic [DATA_W:0] in_sync;
    logic rdy_s;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            in_meta <= '1;
            in_sync <= '1;
        end else begin
            in_meta <= {link.ready_busy_pin, link.prog_data_port};
            in_sync <= in_meta;
        end
    end

    assign rdy_s = in_sync[DATA_W];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    ppp_prg_state_t state;
    logic [CNT_W-1:0] cnt;
    logic is_read;
    logic is_long;
    logic erased;
    logic refuse;
    logic [MODE_W-1:0] next_mode;

    assign op_ready = (state == PS_IDLE) && prog_enable;
    assign refuse = (op_code == OP_WRITE) && (op_wdata != ERASED) && !erased;

    always_comb begin
        case (op_code)
            OP_READ: next_mode = MODE_READ;
            OP_WRITE: next_mode = MODE_WRITE;
            OP_ERASE: next_mode = MODE_ERASE;
            OP_LOCK_WR: next_mode = MODE_LOCK_WR;
            OP_LOCK_RD: next_mode = MODE_LOCK_RD;
            OP_ID_RD: next_mode = MODE_ID_RD;
            OP_FUSE_WR: next_mode = MODE_FUSE_WR;
            OP_FUSE_RD: next_mode = MODE_FUSE_RD;
            default: next_mode = MODE_NONE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= PS_IDLE;
            cnt <= '0;
            is_read <= 1'b0;
            is_long <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= ERASED;
            rsp_error <= 1'b0;
            {link.mode_sel_a, link.mode_sel_b, link.mode_sel_c, link.mode_sel_d} <= MODE_NONE;
            link.prog_addr_high <= '0;
            link.prog_addr_low <= '0;
            link.prg_data_out <= ERASED;
            link.prg_data_oe <= 1'b0;
            link.prog_strobe_n <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                PS_IDLE: begin
                    if (op_valid && op_ready) begin
                        rsp_error <= refuse;
                        is_read <= (op_code == OP_READ) || (op_code == OP_LOCK_RD) ||
                                   (op_code == OP_ID_RD) || (op_code == OP_FUSE_RD);
                        is_long <= (op_code == OP_ERASE) || (op_code == OP_FUSE_WR);
                        cnt <= CNT_W'(SETUP_CYC);
                        if (refuse) begin
                            state <= PS_DONE;
                        end else begin
                            {link.mode_sel_a, link.mode_sel_b, link.mode_sel_c,
                             link.mode_sel_d} <= next_mode;
                            {link.prog_addr_high, link.prog_addr_low} <= op_addr;
                            link.prg_data_out <= op_wdata;
                            link.prg_data_oe <= (op_code == OP_WRITE) ||
                                                (op_code == OP_LOCK_WR) ||
                                                (op_code == OP_FUSE_WR);
                            state <= PS_SETUP;
                        end
                    end
                end
                PS_SETUP: begin
                    if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end else if (is_read) begin
                        rsp_data <= in_sync[DATA_W-1:0];
                        state <= PS_DONE;
                    end else begin
                        link.prog_strobe_n <= 1'b0;
                        cnt <= is_long ? CNT_W'(ERASE_PULSE_CYCLES - 1)
                                       : CNT_W'(PW_CYC - 1);
                        state <= PS_PULSE;
                    end
                end
                PS_PULSE: begin
                    if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        link.prog_strobe_n <= 1'b1;
                        cnt <= CNT_W'(SETUP_CYC);
                        state <= PS_HOLD;
                    end
                end
                PS_HOLD: begin
                    if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        cnt <= CNT_W'(READY_TIMEOUT_CYCLES);
                        state <= PS_WAIT_RDY;
                    end
                end
                PS_WAIT_RDY: begin
                    if (rdy_s) begin
                        state <= PS_DONE;
                    end else if (cnt == '0) begin
                        rsp_error <= 1'b1;
                        state <= PS_DONE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                PS_DONE: begin
                    rsp_valid <= 1'b1;
                    {link.mode_sel_a, link.mode_sel_b, link.mode_sel_c, link.mode_sel_d} <= MODE_NONE;
                    link.prg_data_oe <= 1'b0;
                    state <= PS_IDLE;
                end
                default: begin
                    state <= PS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Erase bookkeeping and programming-mode pins
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || !prog_enable) begin
            erased <= 1'b0;
        end else if (state == PS_WAIT_RDY && rdy_s && is_long &&
                     link.mode_sel_a && !link.mode_sel_c) begin
            erased <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link.rst_pin <= 1'b0;
            link.code_fetch_strobe_n <= 1'b1;
            link.vpp_on <= 1'b0;
        end else begin
            link.rst_pin <= prog_enable;
            link.code_fetch_strobe_n <= !prog_enable;
            link.vpp_on <= prog_enable;
        end
    end
endmodule : ppp_programmer

/* sim/ppp_assertions.sv */
`timescale 1ns/1ps
module ppp_assertions
    import ppp_pkg::*;
#(
    parameter int ERASE_PULSE_CYCLES = 200,
    parameter logic [7:0] ID_MFR = 8'h5a // Arbitrary value
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic rst_pin,
    input wire logic code_fetch_strobe_n,
    input wire logic vpp_on,
    input wire logic mode_sel_a,
    input wire logic mode_sel_b,
    input wire logic mode_sel_c,
    input wire logic mode_sel_d,
    input wire logic prog_strobe_n,
    input wire logic [5:0] prog_addr_high,
    input wire logic [7:0] prog_addr_low,
    input wire logic [7:0] dev_data_out,
    input wire logic dev_data_oe,
    input wire logic rb_oe
);
    logic [3:0] mode;
    logic [13:0] addr;
    logic ctl;
    logic wr_mode;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] busy_cnt;
    assign mode = {mode_sel_a, mode_sel_b, mode_sel_c, mode_sel_d};
    assign addr = {prog_addr_high, prog_addr_low};
    assign ctl = rst_pin && vpp_on && !code_fetch_strobe_n && prog_strobe_n;
    assign wr_mode = mode == MODE_WRITE || mode == MODE_LOCK_WR;
    // ---------------------------------------------
    // Pulse and busy length counters
    // ---------------------------------------------
    always_ff @(posedge mclk) begin
        low_cnt <= prog_strobe_n ? '0 : low_cnt + 1'b1;
    end
    always_ff @(posedge mclk) begin
        busy_cnt <= rb_oe ? busy_cnt + 1'b1 : '0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    entry_ctl_a: assert property (
        !prog_strobe_n |-> rst_pin && vpp_on && !code_fetch_strobe_n)
        else $error("strobe low outside programming entry");
    busy_start_a: assert property (
        $rose(prog_strobe_n) && mode != MODE_NONE && !rb_oe |-> ##[1:40] rb_oe)
        else $error("busy not shown after strobe rise");
    busy_len_a: assert property (busy_cnt <= 80000)
        else $error("busy longer than write cycle limit");
    no_pulse_busy_a: assert property (rb_oe |-> prog_strobe_n)
        else $error("strobe pulsed while busy");
    pulse_width_a: assert property (
        $rose(prog_strobe_n) && wr_mode |-> low_cnt >= 40 && low_cnt <= 4400)
        else $error("program pulse width out of range");
    erase_width_a: assert property (
        $rose(prog_strobe_n) && mode == MODE_ERASE |-> low_cnt >= ERASE_PULSE_CYCLES - 1)
        else $error("erase pulse too short");
    read_drive_a: assert property (
        (ctl && mode == MODE_READ && $stable(addr))[*8] |-> dev_data_oe)
        else $error("read data not driven");
    lock_read_a: assert property (
        (ctl && mode == MODE_LOCK_RD)[*8] |-> dev_data_oe && dev_data_out[7:3] == 5'h00)
        else $error("lock readback malformed");
    fuse_read_a: assert property (
        (ctl && mode == MODE_FUSE_RD)[*8] |-> dev_data_oe && dev_data_out[7:1] == 7'h00)
        else $error("fuse readback malformed");
    id_read_a: assert property (
        (ctl && mode == MODE_ID_RD && addr == ID_ADDR_MFR)[*8] |-> dev_data_out == ID_MFR)
        else $error("maker byte wrong");
    idle_mode_a: assert property ($rose(rb_oe) |-> mode != MODE_NONE)
        else $error("busy in unlisted mode");
endmodule : ppp_assertions

/* sim/parallel_flash_programming_port_tb.sv */
`timescale 1ns/1ps
module parallel_flash_programming_port_tb;
    import ppp_pkg::*;
    localparam int ERASE_CYC = 200;
    localparam logic [7:0] ID_MFR = 8'h5a; // Arbitrary value
    localparam logic [7:0] ID_DEV = 8'ha5; // Arbitrary value
    logic mclk, rst_n, prog_enable, op_valid, op_ready, rsp_valid, rsp_error, fuse, prog_busy;
    ppp_op_t op_code;
    logic [13:0] op_addr;
    logic [7:0] op_wdata, rsp_data;
    logic [2:0] lock_bits;
    int fail_count, cmp_count;
    int busy_seen;
    logic [7:0] lock_wd [3] = '{8'hbf, 8'h7f, 8'hdf};
    logic [7:0] lock_rd [3] = '{8'h02, 8'h06, 8'h07};
    logic [7:0] lock_pins [3] = '{8'h02, 8'h03, 8'h07};
    ppp_if link_if();
    ppp_device #(.WRITE_CYCLES(100)) ppp_device_i (
        .mclk(mclk), .rst_n(rst_n), .link(link_if.dev), .lock_bits(lock_bits),
        .serial_prog_fuse(fuse), .prog_busy(prog_busy)
    );
    ppp_programmer #(.ERASE_PULSE_CYCLES(ERASE_CYC), .READY_TIMEOUT_CYCLES(20000))
    ppp_programmer_i (
        .mclk(mclk), .rst_n(rst_n), .link(link_if.prg), .prog_enable(prog_enable),
        .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_addr(op_addr),
        .op_wdata(op_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_error(rsp_error)
    );
    ppp_assertions #(.ERASE_PULSE_CYCLES(ERASE_CYC), .ID_MFR(ID_MFR)) ppp_assertions_i (
        .mclk(mclk), .rst_n(rst_n), .rst_pin(link_if.rst_pin),
        .code_fetch_strobe_n(link_if.code_fetch_strobe_n), .vpp_on(link_if.vpp_on),
        .mode_sel_a(link_if.mode_sel_a), .mode_sel_b(link_if.mode_sel_b),
        .mode_sel_c(link_if.mode_sel_c), .mode_sel_d(link_if.mode_sel_d),
        .prog_strobe_n(link_if.prog_strobe_n), .prog_addr_high(link_if.prog_addr_high),
        .prog_addr_low(link_if.prog_addr_low), .dev_data_out(link_if.dev_data_out),
        .dev_data_oe(link_if.dev_data_oe), .rb_oe(link_if.rb_oe)
    );
    // Busy cycles seen since the last operation was taken
    always @(posedge mclk) begin
        if (op_valid) begin
            busy_seen <= 0;
        end else if (prog_busy === 1'b1) begin
            busy_seen <= busy_seen + 1;
        end
    end
    // ---------------------------------------------
    // Reporting
    // ---------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wait_high(ref logic sig, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (sig !== 1'b1 && n < lim);
        if (sig !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: handshake timed out", $time);
            complete_run();
        end
    endtask : wait_high
    // ---------------------------------------------
    // One programmer operation with its checks
    // ---------------------------------------------
    task automatic do_op(input ppp_op_t code, input logic [13:0] addr, input logic [7:0] wd,
            input logic [7:0] exp_d, input logic exp_e);
        logic busy_exp;
        busy_exp = !exp_e && (code inside {OP_WRITE, OP_ERASE, OP_LOCK_WR, OP_FUSE_WR});
        wait_high(op_ready, 50);
        @(posedge mclk);
        op_code <= code;
        op_addr <= addr;
        op_wdata <= wd;
        op_valid <= 1'b1;
        @(posedge mclk);
        op_valid <= 1'b0;
        wait_high(rsp_valid, 20000);
        check({7'h00, rsp_error}, {7'h00, exp_e}, "error flag");
        if (code inside {OP_READ, OP_LOCK_RD, OP_ID_RD, OP_FUSE_RD}) begin
            check(rsp_data, exp_d, "read data");
        end
        check({7'h00, link_if.ready_busy_pin}, 8'h01, "ready pin");
        check({7'h00, prog_busy}, 8'h00, "busy flag");
        check({7'h00, busy_seen != 0}, {7'h00, busy_exp}, "busy shown");
        @(posedge mclk);
    endtask : do_op
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        rst_n = 1'b0;
        prog_enable = 1'b0;
        op_valid = 1'b0;
        op_code = OP_READ;
        op_addr = 14'h0000;
        op_wdata = 8'h00;
        fail_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        prog_enable <= 1'b1;
        repeat (8) @(posedge mclk);
        do_op(OP_WRITE, 14'h0000, 8'h12, 8'h00, 1'b1);
        do_op(OP_ERASE, 14'h1234, 8'h5a, 8'h00, 1'b0);
        do_op(OP_READ, 14'h2fff, 8'h00, 8'hff, 1'b0);
        do_op(OP_WRITE, 14'h2fff, 8'h3c, 8'h00, 1'b0);
        do_op(OP_WRITE, 14'h0000, 8'hc3, 8'h00, 1'b0);
        do_op(OP_READ, 14'h2fff, 8'h00, 8'h3c, 1'b0);
        do_op(OP_READ, 14'h0000, 8'h00, 8'hc3, 1'b0);
        do_op(OP_ID_RD, ID_ADDR_MFR, 8'h00, ID_MFR, 1'b0);
        do_op(OP_ID_RD, ID_ADDR_DEV, 8'h00, ID_DEV, 1'b0);
        for (int i = 0; i < 3; i++) begin
            do_op(OP_LOCK_WR, 14'h0000, lock_wd[i], 8'h00, 1'b0);
            do_op(OP_LOCK_RD, 14'h0000, 8'h00, lock_rd[i], 1'b0);
            check({5'h00, lock_bits}, lock_pins[i], "lock bits");
        end
        for (int i = 0; i < 2; i++) begin
            do_op(OP_FUSE_WR, 14'h0000, 8'(1 - i), 8'h00, 1'b0);
            do_op(OP_FUSE_RD, 14'h0000, 8'h00, 8'(1 - i), 1'b0);
            check({7'h00, fuse}, 8'(1 - i), "fuse");
        end
        do_op(OP_ERASE, 14'h0000, 8'h00, 8'h00, 1'b0);
        do_op(OP_LOCK_RD, 14'h0000, 8'h00, 8'h00, 1'b0);
        do_op(OP_READ, 14'h0000, 8'h00, 8'hff, 1'b0);
        prog_enable <= 1'b0;
        repeat (6) @(posedge mclk);
        prog_enable <= 1'b1;
        repeat (8) @(posedge mclk);
        do_op(OP_WRITE, 14'h0001, 8'h00, 8'h00, 1'b1);
        complete_run();
    end
endmodule : parallel_flash_programming_port_tb
